// ---- pkg/tpg_pkg.sv ----
// Constants for the output lane test pattern generator
package tpg_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int LANES  = 4;
  localparam int PIX_W  = 10;
  localparam int REG_W  = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 6;
  localparam int LOW_W  = 8;
  localparam int HIGH_W = 2;
  localparam int IDX_LSB = 2;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_SPARE_STATUS_A = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_SPARE_STATUS_B = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_SPARE_CONTROL_A = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_SPARE_CONTROL_B = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_MODE_CONTROL = 6'h10;
  localparam logic [IDX_W-1:0] IDX_SPARE_CONTROL_C = 6'h11;
  localparam logic [IDX_W-1:0] IDX_LANE01_LOW = 6'h12;
  localparam logic [IDX_W-1:0] IDX_LANE23_LOW = 6'h13;
  localparam logic [IDX_W-1:0] IDX_SPARE_PATTERN_A = 6'h14;
  localparam logic [IDX_W-1:0] IDX_SPARE_PATTERN_B = 6'h15;
  localparam logic [IDX_W-1:0] IDX_HIGH_BITS = 6'h16;
  localparam logic [IDX_W-1:0] IDX_PATTERN_STATUS = 6'h17;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_ZERO          = 16'h0000;
  localparam logic [REG_W-1:0] RST_SPARE_CTL_B   = 16'hffff;
  localparam logic [REG_W-1:0] RST_LANE01_LOW    = 16'h0100;
  localparam logic [REG_W-1:0] RST_LANE23_LOW    = 16'h0302;
  localparam logic [REG_W-1:0] RST_SPARE_PAT_A   = 16'h0504;
  localparam logic [REG_W-1:0] RST_SPARE_PAT_B   = 16'h0706;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_EN_BIT    = 0;
  localparam int MODE_INC_BIT   = 1;
  localparam int MODE_PRBS_BIT  = 2;
  localparam int MODE_FRAME_BIT = 3;
  localparam int ST_ACTIVE_BIT  = 10;
  localparam int ST_PRBS_BIT    = 11;

  // ---------------------------------------------------------------
  // PRBS: x^9 + x^5 + 1, one seed per lane
  // ---------------------------------------------------------------
  localparam int PRBS_W     = 9;
  localparam int PRBS_TAP_A = 8;
  localparam int PRBS_TAP_B = 4;
  // Lane 0 seed in the low nine bits; no seed may be zero or its LFSR locks up
  localparam logic [LANES*PRBS_W-1:0] PRBS_SEEDS = {9'h1ff, 9'h0aa, 9'h155, 9'h0f1};

endpackage

// ---- pkg/lane_if.sv ----
// Link between the output stage and the PRBS lane generator
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
  import tpg_pkg::*;
  logic                   step;     // Advance one word on every lane
  logic                   restart;  // Reload the seeds
  logic [LANES*PIX_W-1:0] word;     // Current word, lane 0 in the low bits

  modport gen  (input step, input restart, output word);
  modport user (output step, output restart, input word);
endinterface // lane_if
`default_nettype wire

// ---- rtl/prbs_lane_gen.sv ----
// PRBS word generator, one LFSR per lane
`timescale 1ns/1ps
`default_nettype none
module prbs_lane_gen
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic I_CLOCK,
  input  wire logic I_RESETN,
  // Link to the output stage
  lane_if.gen       lane
);

  // Ten serial steps per word; returns next state above the word bits
  function automatic logic [PRBS_W+PIX_W-1:0] advance(input logic [PRBS_W-1:0] s);
    logic [PRBS_W-1:0] t;
    logic [PIX_W-1:0]  b;
    logic              fb;
    t = s;
    b = '0;
    for (int k = 0; k < PIX_W; k++)
    begin
      fb = t[PRBS_TAP_A] ^ t[PRBS_TAP_B];
      b  = {b[PIX_W-2:0], fb};
      t  = {t[PRBS_W-2:0], fb};
    end
    return {t, b};
  endfunction

  // -----------------------------------------------------------------
  // Per-lane generators
  // -----------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [PRBS_W-1:0] state_r;
    logic [PIX_W-1:0]  word_r;
    logic [PRBS_W+PIX_W-1:0] nxt;
    assign nxt = advance(state_r);

    // Restart reloads the seed and clears the word; the first sequence word comes on the next step
    always_ff @(posedge I_CLOCK)
    begin
      if (!I_RESETN || lane.restart)
      begin
        state_r <= PRBS_SEEDS[l*PRBS_W +: PRBS_W];
        word_r  <= '0;
      end
      else if (lane.step)
      begin
        state_r <= nxt[PIX_W +: PRBS_W];
        word_r  <= nxt[PIX_W-1:0];
      end
    end
    assign lane.word[l*PIX_W +: PIX_W] = word_r;
  end

endmodule // prbs_lane_gen
`default_nettype wire

// ---- rtl/lane_pattern_gen.sv ----
// Output lane test pattern generator with APB register bank
`timescale 1ns/1ps
`default_nettype none
module lane_pattern_gen
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic                   I_CLOCK,
  input  wire logic                   I_RESETN,
  // APB slave
  input  wire logic                   I_PSEL,
  input  wire logic                   I_PENABLE,
  input  wire logic                   I_PWRITE,
  input  wire logic [ADDR_W-1:0]      I_PADDR,
  input  wire logic [DATA_W-1:0]      I_PWDATA,
  output logic      [DATA_W-1:0]      O_PRDATA,
  output logic                        O_PREADY,
  output logic                        O_PSLVERR,
  // Pixel stream in
  input  wire logic [LANES*PIX_W-1:0] I_PIX_DATA,
  input  wire logic                   I_PIX_VALID,
  input  wire logic                   I_FRAME_VALID,
  input  wire logic                   I_LINE_VALID,
  // Lane stream out
  output logic      [LANES*PIX_W-1:0] O_LANE_DATA,
  output logic                        O_DATA_VALID,
  output logic                        O_FRAME_VALID,
  output logic                        O_LINE_VALID
);

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [REG_W-1:0] spare_ctl_a_r;
  logic [REG_W-1:0] spare_ctl_b_r;
  logic [REG_W-1:0] mode_r;
  logic [REG_W-1:0] spare_ctl_c_r;
  logic [REG_W-1:0] lane01_low_r;
  logic [REG_W-1:0] lane23_low_r;
  logic [REG_W-1:0] spare_pat_a_r;
  logic [REG_W-1:0] spare_pat_b_r;
  logic [REG_W-1:0] high_bits_r;
  logic [REG_W-1:0] status;
  logic [REG_W-1:0] rd_nxt;
  logic             mapped;

  lane_if lane ();

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  logic             access;
  logic             wr_fire;
  logic [IDX_W-1:0] idx;
  assign access  = I_PSEL && I_PENABLE;
  assign wr_fire = access && O_PREADY && I_PWRITE && mapped;
  assign idx     = I_PADDR[ADDR_W-1:IDX_LSB];

  // Read mux; misaligned addresses count as unmapped
  always_comb
  begin
    rd_nxt = RST_ZERO;
    mapped = (I_PADDR[IDX_LSB-1:0] == '0);
    case (idx)
      IDX_SPARE_STATUS_A:  rd_nxt = RST_ZERO;
      IDX_SPARE_STATUS_B:  rd_nxt = RST_ZERO;
      IDX_SPARE_CONTROL_A: rd_nxt = spare_ctl_a_r;
      IDX_SPARE_CONTROL_B: rd_nxt = spare_ctl_b_r;
      IDX_MODE_CONTROL:    rd_nxt = mode_r;
      IDX_SPARE_CONTROL_C: rd_nxt = spare_ctl_c_r;
      IDX_LANE01_LOW:      rd_nxt = lane01_low_r;
      IDX_LANE23_LOW:      rd_nxt = lane23_low_r;
      IDX_SPARE_PATTERN_A: rd_nxt = spare_pat_a_r;
      IDX_SPARE_PATTERN_B: rd_nxt = spare_pat_b_r;
      IDX_HIGH_BITS:       rd_nxt = high_bits_r;
      IDX_PATTERN_STATUS:  rd_nxt = status;
      default:             mapped = 1'b0;
    endcase
  end

  // One wait state so read data and ready come from flops
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= '0;
    end
    else
    begin
      O_PREADY  <= access && !O_PREADY;
      O_PSLVERR <= access && !O_PREADY && !mapped;
      O_PRDATA  <= (access && !O_PREADY && !I_PWRITE) ? {{(DATA_W-REG_W){1'b0}}, rd_nxt} : '0;
    end
  end

  // Register writes; status and spare status words are read-only
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      spare_ctl_a_r <= RST_ZERO;
      spare_ctl_b_r <= RST_SPARE_CTL_B;
      mode_r        <= RST_ZERO;
      spare_ctl_c_r <= RST_ZERO;
      lane01_low_r  <= RST_LANE01_LOW;
      lane23_low_r  <= RST_LANE23_LOW;
      spare_pat_a_r <= RST_SPARE_PAT_A;
      spare_pat_b_r <= RST_SPARE_PAT_B;
      high_bits_r   <= RST_ZERO;
    end
    else if (wr_fire)
    begin
      case (idx)
        IDX_SPARE_CONTROL_A: spare_ctl_a_r <= I_PWDATA[REG_W-1:0];
        IDX_SPARE_CONTROL_B: spare_ctl_b_r <= I_PWDATA[REG_W-1:0];
        IDX_MODE_CONTROL:    mode_r        <= I_PWDATA[REG_W-1:0];
        IDX_SPARE_CONTROL_C: spare_ctl_c_r <= I_PWDATA[REG_W-1:0];
        IDX_LANE01_LOW:      lane01_low_r  <= I_PWDATA[REG_W-1:0];
        IDX_LANE23_LOW:      lane23_low_r  <= I_PWDATA[REG_W-1:0];
        IDX_SPARE_PATTERN_A: spare_pat_a_r <= I_PWDATA[REG_W-1:0];
        IDX_SPARE_PATTERN_B: spare_pat_b_r <= I_PWDATA[REG_W-1:0];
        IDX_HIGH_BITS:       high_bits_r   <= I_PWDATA[REG_W-1:0];
        default:             ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Mode decode
  // -----------------------------------------------------------------
  logic prbs_on;
  logic pat_on;
  logic inc_on;
  logic test_on;
  logic framed;
  logic advance;
  logic frame_d_r;
  logic frame_start;
  logic reload;

  assign prbs_on = mode_r[MODE_PRBS_BIT];
  assign pat_on  = mode_r[MODE_EN_BIT] && !prbs_on;
  assign inc_on  = pat_on && mode_r[MODE_INC_BIT];
  assign test_on = prbs_on || mode_r[MODE_EN_BIT];
  assign framed  = mode_r[MODE_FRAME_BIT];
  // Framed patterns advance with the pixel timing; unframed every cycle
  assign advance = test_on && (framed ? I_PIX_VALID : 1'b1);
  assign frame_start = I_FRAME_VALID && !frame_d_r;
  // Each framed frame restarts the count from the programmed value
  assign reload  = !inc_on || (framed && frame_start);

  // Frame edge detect
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      frame_d_r <= 1'b0;
    else
      frame_d_r <= I_FRAME_VALID;
  end

  // PRBS generator holds its seeds while PRBS is off
  assign lane.step    = prbs_on && advance;
  assign lane.restart = !prbs_on;

  prbs_lane_gen u_prbs (
    .I_CLOCK  (I_CLOCK),
    .I_RESETN (I_RESETN),
    .lane     (lane)
  );

  // -----------------------------------------------------------------
  // Per-lane pattern words
  // -----------------------------------------------------------------
  logic [LANES*PIX_W-1:0] const_flat;
  logic [LANES*PIX_W-1:0] word_nxt;

  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [REG_W-1:0] low_pair;
    logic [PIX_W-1:0] prog;
    logic [PIX_W-1:0] cnt_r;

    // Lanes 0 and 1 share one word, lanes 2 and 3 the other
    assign low_pair = (l < 2) ? lane01_low_r : lane23_low_r;
    assign prog = {high_bits_r[l*HIGH_W +: HIGH_W],
                   low_pair[(l%2)*LOW_W +: LOW_W]};
    assign const_flat[l*PIX_W +: PIX_W] = prog;

    // Counter wraps naturally at ten bits
    always_ff @(posedge I_CLOCK)
    begin
      if (!I_RESETN)
        cnt_r <= '0;
      else if (reload)
        cnt_r <= prog + PIX_W'(advance && inc_on);
      else if (advance)
        cnt_r <= cnt_r + PIX_W'(1);
    end

    // Priority: PRBS, then increment, then constant
    assign word_nxt[l*PIX_W +: PIX_W] =
      prbs_on ? lane.word[l*PIX_W +: PIX_W] :
      (inc_on && !reload) ? cnt_r :
      (inc_on ? prog : prog);
  end

  // -----------------------------------------------------------------
  // Output stage
  // -----------------------------------------------------------------
  // Unframed test patterns drop the frame and line markers; pass-through keeps them
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      O_LANE_DATA   <= '0;
      O_DATA_VALID  <= 1'b0;
      O_FRAME_VALID <= 1'b0;
      O_LINE_VALID  <= 1'b0;
    end
    else if (!test_on)
    begin
      O_LANE_DATA   <= I_PIX_DATA;
      O_DATA_VALID  <= I_PIX_VALID;
      O_FRAME_VALID <= I_FRAME_VALID;
      O_LINE_VALID  <= I_LINE_VALID;
    end
    else
    begin
      O_LANE_DATA   <= word_nxt;
      O_DATA_VALID  <= framed ? I_PIX_VALID : 1'b1;
      O_FRAME_VALID <= framed && I_FRAME_VALID;
      O_LINE_VALID  <= framed && I_LINE_VALID;
    end
  end

  // Status word: lane 0 output and the active mode
  always_comb
  begin
    status = RST_ZERO;
    status[PIX_W-1:0]    = O_LANE_DATA[PIX_W-1:0];
    status[ST_ACTIVE_BIT] = test_on;
    status[ST_PRBS_BIT]   = prbs_on;
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_two_inc;
    (inc_on && advance && !reload) ##1 (inc_on && advance && !reload);
  endsequence

  sequence s_apb_wait;
    access && !O_PREADY;
  endsequence

  chk_const_word: assert property (
    (pat_on && !inc_on) |=> (O_LANE_DATA == $past(const_flat)))
    else $error("constant pattern not on lanes");

  chk_inc_step: assert property (
    s_two_inc |=> (O_LANE_DATA[PIX_W-1:0] == PIX_W'($past(O_LANE_DATA[PIX_W-1:0]) + 1)))
    else $error("increment pattern did not step by one");

  chk_prbs_wins: assert property (
    prbs_on |=> (O_LANE_DATA == $past(lane.word)))
    else $error("PRBS word not on lanes");

  chk_unframed_out: assert property (
    (test_on && !framed) |=> (O_DATA_VALID && !O_FRAME_VALID && !O_LINE_VALID))
    else $error("unframed output carries framing");

  chk_framed_out: assert property (
    (test_on && framed) |=>
      (O_DATA_VALID == $past(I_PIX_VALID) && O_LINE_VALID == $past(I_LINE_VALID)))
    else $error("framed output lost pixel timing");

  chk_reset_low: assert property (
    !$past(I_RESETN) |-> (lane01_low_r == RST_LANE01_LOW && lane23_low_r == RST_LANE23_LOW))
    else $error("pattern low bytes wrong after reset");

  chk_high_write: assert property (
    (wr_fire && idx == IDX_HIGH_BITS) |=> (high_bits_r == $past(I_PWDATA[REG_W-1:0])))
    else $error("high-bits write not stored");

  chk_apb_ready: assert property (
    s_apb_wait |=> O_PREADY ##1 !O_PREADY)
    else $error("APB ready not one cycle after access");

  chk_pass_thru: assert property (
    !test_on |=> (O_LANE_DATA == $past(I_PIX_DATA)))
    else $error("pixel data not passed through");

endmodule // lane_pattern_gen
`default_nettype wire

// ---- sim/lane_receiver.sv ----
// Receiver model that collects the words leaving the lanes
`timescale 1ns/1ps
`default_nettype none
module lane_receiver
  import tpg_pkg::*;
(
  // Clock and control
  input  wire logic                   i_clock,
  input  wire logic                   i_clear,
  // Lane stream
  input  wire logic [LANES*PIX_W-1:0] i_lane_data,
  input  wire logic                   i_data_valid,
  input  wire logic                   i_frame_valid,
  // Collected results
  output logic      [LANES*PIX_W-1:0] o_last_word,
  output logic      [15:0]            o_word_count
);
  // Only words inside a frame count, as a framing receiver would
  always_ff @(posedge i_clock)
  begin
    if (i_clear)
      o_word_count <= 16'h0000;
    else if (i_data_valid && i_frame_valid)
    begin
      o_word_count <= o_word_count + 16'h0001;
      o_last_word  <= i_lane_data;
    end
  end
endmodule // lane_receiver
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the lane pattern generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpg_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pix_v, frm_v, lin_v, clr;
  logic        dv, fv, lv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] pix, lanes, last_w;
  logic [15:0] cnt;
  logic        err;
  int          failures, checks;

  lane_pattern_gen u_lane_pattern_gen (.I_CLOCK(clk), .I_RESETN(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PIX_DATA(pix),
    .I_PIX_VALID(pix_v), .I_FRAME_VALID(frm_v), .I_LINE_VALID(lin_v),
    .O_LANE_DATA(lanes), .O_DATA_VALID(dv), .O_FRAME_VALID(fv), .O_LINE_VALID(lv));
  lane_receiver u_lane_receiver (.i_clock(clk), .i_clear(clr), .i_lane_data(lanes),
    .i_data_valid(dv), .i_frame_valid(fv), .o_last_word(last_w), .o_word_count(cnt));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reference LFSR: ten serial steps per lane word, first bit in the MSB
  function automatic logic [18:0] prbs_next(input logic [8:0] s);
    logic [8:0] t;
    logic [9:0] b;
    logic       fb;
    t = s;
    b = '0;
    for (int k = 0; k < 10; k++)
    begin
      fb = t[PRBS_TAP_A] ^ t[PRBS_TAP_B];
      b  = {b[8:0], fb};
      t  = {t[7:0], fb};
    end
    return {t, b};
  endfunction

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_map;
    logic [5:0]  idx [11] = '{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h10, 6'h11, 6'h12, 6'h13,
                              6'h14, 6'h15, 6'h16};
    logic [15:0] exp [11] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000,
                              16'h0100, 16'h0302, 16'h0504, 16'h0706, 16'h0000};
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, idx[i], 16'h0000);
      chk(rd, exp[i], "reset value");
    end
    apb(1'b1, 6'h0a, 16'h1234);
    apb(1'b0, 6'h0a, 16'h0000);
    chk(rd, 0, "read-only spare");
    apb(1'b0, 6'h20, 16'h0000);
    chk({rd, 7'h00, err}, 40'h1, "unmapped refused");
  endtask

  task automatic t_pass;
    @(posedge clk);
    pix <= 40'h12_3456_789a;
    {pix_v, frm_v, lin_v} <= 3'b101;
    @(posedge clk);
    @(negedge clk);
    chk(lanes, 40'h12_3456_789a, "pass-through");
    chk({dv, fv, lv}, 3'b101, "pass-through valids");
  endtask

  // Lanes 0..3 = 0x0a1, 0x1b2, 0x2c3, 0x3d4; valids ignored when unframed
  task automatic t_const;
    apb(1'b1, 6'h12, 16'hb2a1);
    apb(1'b1, 6'h13, 16'hd4c3);
    apb(1'b1, 6'h16, 16'h00e4);
    apb(1'b1, 6'h10, 16'h0001);
    frm_v <= 1'b1;
    lin_v <= 1'b1;
    pix_v <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(lanes, {10'h3d4, 10'h2c3, 10'h1b2, 10'h0a1}, "constant");
    chk({dv, fv, lv}, 3'b100, "unframed valids");
  endtask

  // Lane 0 programmed 0x3fe so the count wraps
  task automatic t_inc;
    int n;
    apb(1'b1, 6'h12, 16'hb2fe);
    apb(1'b1, 6'h16, 16'h00e7);
    apb(1'b1, 6'h10, 16'h0003);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (lanes[9:0] === 10'h3fe && n < 6);
    chk(lanes[9:0], 10'h3ff, "increment step");
    @(negedge clk);
    chk(lanes[9:0], 10'h000, "increment wrap");
    chk(lanes[19:10], 10'h1b4, "lane 1 increment");
  endtask

  // Framed increment: only valid words advance the count
  task automatic t_framed;
    @(posedge clk);
    frm_v <= 1'b0;
    lin_v <= 1'b0;
    apb(1'b1, 6'h10, 16'h000b);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    frm_v <= 1'b1;
    lin_v <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      pix_v <= i[0];
      @(posedge clk);
    end
    pix_v <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({fv, lv}, 2'b11, "framed valids");
    chk(cnt, 3, "framed word count");
    chk(last_w[9:0], 10'h000, "framed advance");
    @(posedge clk);
    frm_v <= 1'b0;
  endtask

  // PRBS alone, then together with the pattern; each pass restarts from the seeds
  task automatic t_prbs;
    logic [39:0] prev;
    logic [8:0]  st [4];
    logic [18:0] nx;
    int          moves;
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, 6'h10, 16'h0000);
      apb(1'b1, 6'h10, m ? 16'h0005 : 16'h0004);
      for (int l = 0; l < 4; l++)
        st[l] = PRBS_SEEDS[l*PRBS_W +: PRBS_W];
      moves = 0;
      prev = lanes;
      for (int j = 0; j < 8; j++)
      begin
        @(negedge clk);
        if (lanes !== prev && lanes !== pix && lanes[9:0] !== 10'h3fe)
          moves++;
        prev = lanes;
        if (j == 1)
          chk(lanes, 40'h0, "PRBS first word");
        for (int l = 0; l < 4 && j > 1; l++)
        begin
          nx = prbs_next(st[l]);
          st[l] = nx[18:10];
          chk(lanes[l*10 +: 10], nx[9:0], "PRBS word");
        end
      end
      chk(moves > 5, 1, "PRBS moving");
      apb(1'b0, 6'h17, 16'h0000);
      chk(rd[11], 1, "PRBS status");
      chk(rd[10], 1, "test active status");
    end
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done();
  end

  initial
  begin
    failures = 0;
    checks = 0;
    {rst_n, psel, penable, pwrite, pix_v, frm_v, lin_v, clr} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pix = 40'h00_0000_0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_map();
    t_pass();
    t_const();
    t_inc();
    t_framed();
    t_prbs();
    test_done();
  end
endmodule // tb
`default_nettype wire
